// file: hdl/mlb_regs.vh
`ifndef MLB_REGS_VH
`define MLB_REGS_VH

// ****************************************
// bus timing
// ****************************************
`define MLB_CLK_SYS_NS      10
`define MLB_CLKS_PER_TSTATE 2
`define MLB_MIN_TSTATES     4

// ****************************************
// t-state codes
// ****************************************
`define MLB_ST_TI 3'h0
`define MLB_ST_T1 3'h1
`define MLB_ST_T2 3'h2
`define MLB_ST_T3 3'h3
`define MLB_ST_TW 3'h4
`define MLB_ST_T4 3'h5

// ****************************************
// cycle status codes
// ****************************************
`define MLB_CYC_INTA    3'h0
`define MLB_CYC_IO_RD   3'h1
`define MLB_CYC_IO_WR   3'h2
`define MLB_CYC_HALT    3'h3
`define MLB_CYC_FETCH   3'h4
`define MLB_CYC_MEM_RD  3'h5
`define MLB_CYC_MEM_WR  3'h6
`define MLB_CYC_PASSIVE 3'h7

// ****************************************
// lane enables {upper, lower}
// ****************************************
`define MLB_LANE_LO   2'h1
`define MLB_LANE_HI   2'h2
`define MLB_LANE_BOTH 2'h3

`endif

// file: hdl/mlb_sync2.v
`timescale 1ns/1ns
`default_nettype none

module mlb_sync2 #(
   parameter W = 18
) (
   input  wire         clk_sys,
   input  wire         rstn,
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);

   reg [W-1:0] meta_r;

   // first stage is read by the second stage only
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_r <= {W{1'b0}};
         q_out  <= {W{1'b0}};
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end

endmodule // mlb_sync2

`default_nettype wire

// file: hdl/mlb_tstate_div.v
`timescale 1ns/1ns
`default_nettype none

module mlb_tstate_div (
   input  wire clk_sys,
   input  wire rstn,
   output reg  st_en,
   output reg  mid_en
);

   // two sys clocks per t-state: start edge, then mid edge
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_en  <= 1'b0;
         mid_en <= 1'b0;
      end else begin
         st_en  <= ~st_en;
         mid_en <= st_en;
      end
   end

endmodule // mlb_tstate_div

`default_nettype wire

// file: hdl/mlb_bus_cycle.v
`timescale 1ns/1ns
`default_nettype none
`include "mlb_regs.vh"

module mlb_bus_cycle (
   input  wire        clk_sys,
   input  wire        rstn,
   input  wire        cfg_bus8,
   input  wire        cfg_pcs_addr,
   input  wire        cpu_req,
   input  wire [2:0]  cpu_cyc,
   input  wire [19:0] cpu_addr,
   input  wire        cpu_word,
   input  wire        cpu_periph,
   input  wire [15:0] cpu_wdata,
   output reg         cpu_done,
   input  wire        dma_req,
   input  wire [2:0]  dma_cyc,
   input  wire [19:0] dma_addr,
   input  wire        dma_word,
   input  wire        dma_periph,
   input  wire [15:0] dma_wdata,
   output reg         dma_done,
   output reg  [15:0] rd_data,
   input  wire        sync_ready_in,
   input  wire        async_ready_in,
   input  wire [15:0] muxed_addr_data_bus_in,
   output reg  [15:0] muxed_addr_data_bus_out,
   output reg         muxed_addr_data_bus_oe,
   output reg  [3:0]  upper_addr_status_lines,
   output reg         high_byte_lane_enable_n,
   output reg  [2:0]  cycle_status_code,
   output reg         ale,
   output reg         rd_n,
   output reg         wr_n,
   output reg         data_buffer_enable_n,
   output reg         data_buffer_direction,
   output reg         pcs_a1,
   output reg         pcs_a2,
   output reg         bus_clk_out
);

   // ****************************************
   // decode helpers
   // ****************************************
   function is_write;
      input [2:0] cyc;
      begin
         is_write = (cyc == `MLB_CYC_IO_WR) || (cyc == `MLB_CYC_MEM_WR);
      end
   endfunction

   function is_read;
      input [2:0] cyc;
      begin
         is_read = (cyc == `MLB_CYC_IO_RD) || (cyc == `MLB_CYC_MEM_RD) ||
                   (cyc == `MLB_CYC_FETCH) || (cyc == `MLB_CYC_INTA);
      end
   endfunction

   // ****************************************
   // phase enables and synchronised pins
   // ****************************************
   wire        st_en;
   wire        mid_en;
   wire [17:0] pin_s;

   mlb_tstate_div u_div (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .st_en   (st_en),
      .mid_en  (mid_en)
   );

   mlb_sync2 #(.W(18)) u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d_in    ({sync_ready_in, async_ready_in, muxed_addr_data_bus_in}),
      .q_out   (pin_s)
   );

   wire        rdy_s  = pin_s[17] | pin_s[16];
   wire [15:0] bus_s  = pin_s[15:0];

   // ****************************************
   // state
   // ****************************************
   reg  [2:0]  st_r;
   reg         dec_r;
   reg         pend_r;
   reg         ann_r;
   reg         rdy_m_r;
   reg         busy_r;
   reg         own_dma_r;
   reg         sec_left_r;
   reg         second_r;
   reg  [2:0]  cyc_r;
   reg  [19:0] base_r;
   reg  [19:0] cyc_addr_r;
   reg  [1:0]  lane_r;
   reg         word_r;
   reg  [15:0] wdata_r;

   // owner is masked so a held request is not run twice
   wire cpu_live = cpu_req & ~(busy_r & ~own_dma_r);
   wire dma_live = dma_req & ~(busy_r & own_dma_r);
   wire work     = sec_left_r | cpu_live | dma_live;
   wire fin_st   = (st_r == `MLB_ST_T4) || (st_r == `MLB_ST_TI);

   // new request, dma first; both sources share one path
   wire        sel_dma  = dma_live;
   wire [2:0]  sel_cyc  = sel_dma ? dma_cyc : cpu_cyc;
   wire [19:0] sel_addr = sel_dma ? dma_addr : cpu_addr;
   wire        sel_word = sel_dma ? dma_word : cpu_word;
   wire        sel_per  = sel_dma ? dma_periph : cpu_periph;
   wire [15:0] sel_wd   = sel_dma ? dma_wdata : cpu_wdata;
   wire        sel_two  = sel_word & ~(cfg_bus8 & sel_per) & (cfg_bus8 | sel_addr[0]);
   wire [19:0] nxt_addr = base_r + 20'h00001;

   // byte for byte cycles; mirrored on both lanes, the unused copy is don't-care
   wire [7:0]  wbyte    = second_r ? wdata_r[15:8] : wdata_r[7:0];
   wire [15:0] wlane    = (lane_r == `MLB_LANE_BOTH) ? wdata_r : {wbyte, wbyte};
   wire [7:0]  rbyte    = (lane_r == `MLB_LANE_HI) ? bus_s[15:8] : bus_s[7:0];

   // ****************************************
   // t-state sequencer
   // ****************************************
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r                    <= `MLB_ST_TI;
         dec_r                   <= 1'b0;
         pend_r                  <= 1'b0;
         ann_r                   <= 1'b0;
         rdy_m_r                 <= 1'b0;
         busy_r                  <= 1'b0;
         own_dma_r               <= 1'b0;
         sec_left_r              <= 1'b0;
         second_r                <= 1'b0;
         cyc_r                   <= `MLB_CYC_PASSIVE;
         base_r                  <= 20'h00000;
         cyc_addr_r              <= 20'h00000;
         lane_r                  <= `MLB_LANE_LO;
         word_r                  <= 1'b0;
         wdata_r                 <= 16'h0000;
         cpu_done                <= 1'b0;
         dma_done                <= 1'b0;
         rd_data                 <= 16'h0000;
         muxed_addr_data_bus_out <= 16'h0000;
         muxed_addr_data_bus_oe  <= 1'b0;
         upper_addr_status_lines <= 4'h0;
         high_byte_lane_enable_n <= 1'b1;
         cycle_status_code       <= `MLB_CYC_PASSIVE;
         ale                     <= 1'b0;
         rd_n                    <= 1'b1;
         wr_n                    <= 1'b1;
         data_buffer_enable_n    <= 1'b1;
         data_buffer_direction   <= 1'b1;
         pcs_a1                  <= 1'b1;
         pcs_a2                  <= 1'b1;
         bus_clk_out             <= 1'b0;
      end else begin
         cpu_done <= 1'b0;
         dma_done <= 1'b0;
         if (st_en) begin
            bus_clk_out <= 1'b0;
            // one-state pipeline: pend at mid reflects work seen a state earlier
            dec_r  <= work;
            pend_r <= dec_r;
            case (st_r)
               `MLB_ST_TI, `MLB_ST_T4: begin
                  if (ann_r) begin
                     st_r                    <= `MLB_ST_T1;
                     ann_r                   <= 1'b0;
                     muxed_addr_data_bus_out <= cyc_addr_r[15:0];
                     muxed_addr_data_bus_oe  <= 1'b1;
                     upper_addr_status_lines <= cyc_addr_r[19:16];
                     high_byte_lane_enable_n <= cfg_bus8 | ~lane_r[1];
                     data_buffer_direction   <= is_write(cyc_r);
                  end else begin
                     st_r                   <= `MLB_ST_TI;
                     muxed_addr_data_bus_oe <= 1'b0;
                  end
               end
               `MLB_ST_T1: begin
                  st_r                    <= `MLB_ST_T2;
                  upper_addr_status_lines <= 4'h0;
                  data_buffer_enable_n    <= 1'b0;
                  if (is_write(cyc_r)) begin
                     muxed_addr_data_bus_out <= wlane;
                     wr_n                    <= 1'b0;
                  end else begin
                     muxed_addr_data_bus_oe <= 1'b0;
                     rd_n                   <= ~is_read(cyc_r);
                  end
               end
               `MLB_ST_T2: begin
                  st_r <= `MLB_ST_T3;
               end
               `MLB_ST_T3, `MLB_ST_TW: begin
                  if (rdy_m_r) begin
                     st_r                 <= `MLB_ST_T4;
                     rd_n                 <= 1'b1;
                     wr_n                 <= 1'b1;
                     data_buffer_enable_n <= 1'b1;
                     if (is_read(cyc_r)) begin
                        // read data sampled entering the fourth state
                        if (lane_r == `MLB_LANE_BOTH)
                           rd_data <= bus_s;
                        else if (second_r)
                           rd_data[15:8] <= rbyte;
                        else
                           rd_data[7:0] <= rbyte;
                     end
                     if (!sec_left_r) begin
                        cpu_done <= ~own_dma_r;
                        dma_done <= own_dma_r;
                     end
                  end else begin
                     st_r <= `MLB_ST_TW;
                  end
               end
               default: begin
                  st_r <= `MLB_ST_TI;
               end
            endcase
         end
         if (mid_en) begin
            bus_clk_out <= 1'b1;
            if (fin_st) begin
               if (pend_r) begin
                  ale               <= 1'b1;
                  ann_r             <= 1'b1;
                  busy_r            <= 1'b1;
                  if (sec_left_r) begin
                     // second half of a split word: next byte, lower lane
                     sec_left_r        <= 1'b0;
                     second_r          <= 1'b1;
                     cyc_addr_r        <= nxt_addr;
                     lane_r            <= `MLB_LANE_LO;
                     cycle_status_code <= cyc_r;
                  end else begin
                     own_dma_r         <= sel_dma;
                     cyc_r             <= sel_cyc;
                     base_r            <= sel_addr;
                     cyc_addr_r        <= sel_addr;
                     word_r            <= sel_word;
                     wdata_r           <= sel_wd;
                     sec_left_r        <= sel_two;
                     second_r          <= 1'b0;
                     cycle_status_code <= sel_cyc;
                     if (cfg_bus8 || sel_addr[0])
                        lane_r <= sel_addr[0] & ~cfg_bus8 ? `MLB_LANE_HI : `MLB_LANE_LO;
                     else
                        lane_r <= sel_word ? `MLB_LANE_BOTH : `MLB_LANE_LO;
                  end
               end else begin
                  busy_r            <= 1'b0;
                  cycle_status_code <= `MLB_CYC_PASSIVE;
               end
            end
            if (st_r == `MLB_ST_T1) begin
               ale <= 1'b0;
               if (cfg_pcs_addr) begin
                  pcs_a1 <= cyc_addr_r[1];
                  pcs_a2 <= cyc_addr_r[2];
               end
            end
            if (!cfg_pcs_addr) begin
               pcs_a1 <= 1'b1;
               pcs_a2 <= 1'b1;
            end
            if ((st_r == `MLB_ST_T3) || (st_r == `MLB_ST_TW)) begin
               // ready taken mid-state so status and exit agree
               rdy_m_r <= rdy_s;
               if (rdy_s)
                  cycle_status_code <= `MLB_CYC_PASSIVE;
            end
         end
      end
   end

endmodule // mlb_bus_cycle

`default_nettype wire

// file: tb/mlb_bus_cycle_props.sv
`timescale 1ns/1ns
`default_nettype none
module mlb_bus_cycle_props (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        cfg_bus8,
   input wire logic        cpu_done,
   input wire logic        dma_done,
   input wire logic        sync_ready_in,
   input wire logic        async_ready_in,
   input wire logic [15:0] muxed_addr_data_bus_out,
   input wire logic        muxed_addr_data_bus_oe,
   input wire logic [3:0]  upper_addr_status_lines,
   input wire logic        high_byte_lane_enable_n,
   input wire logic [2:0]  cycle_status_code,
   input wire logic        ale,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        data_buffer_enable_n,
   input wire logic        data_buffer_direction
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire any_done = cpu_done | dma_done;
   wire rdy      = sync_ready_in | async_ready_in;
   // ****************************************
   // checks
   // ****************************************
   ale_pulse_a: assert property ($rose(ale) |-> ##1 (muxed_addr_data_bus_oe && ale) ##1 !ale)
      else $error("latch strobe pulse misplaced");
   announce_a: assert property ($rose(ale) |-> cycle_status_code != 3'h7 && $past(cycle_status_code) == 3'h7)
      else $error("status not announced with strobe");
   quiet_a: assert property ((cycle_status_code != 3'h7 && $past(cycle_status_code) == 3'h7) |-> $rose(ale))
      else $error("status left passive without a cycle");
   min_len_a: assert property ($rose(ale) |-> (!any_done) [*7])
      else $error("bus cycle shorter than four states");
   rd_low_a: assert property ($fell(rd_n) |-> (!muxed_addr_data_bus_oe && !data_buffer_enable_n) ##1 (!rd_n) [*3])
      else $error("read strobe window wrong");
   wr_data_a: assert property ($fell(wr_n) |-> muxed_addr_data_bus_oe && data_buffer_direction)
      else $error("write strobe without driven data");
   upper_t1_a: assert property (upper_addr_status_lines != 4'h0 |-> ale || $past(ale))
      else $error("upper address outside first state");
   ready_gate_a: assert property (any_done |-> $past(rdy, 2) || $past(rdy, 3) || $past(rdy, 4) || $past(rdy, 5))
      else $error("cycle ended without ready");
   bus8_lane_a: assert property ((cfg_bus8 && $rose(ale)) |=> high_byte_lane_enable_n)
      else $error("high lane enable in 8-bit mode");
   lane_a: assert property ((!cfg_bus8 && $rose(ale)) |=> !(high_byte_lane_enable_n && muxed_addr_data_bus_out[0]))
      else $error("no byte lane selected");
   cover property ($fell(rd_n));
   cover property ($fell(wr_n));
   cover property (cfg_bus8 && $rose(ale));
endmodule // mlb_bus_cycle_props
bind mlb_bus_cycle mlb_bus_cycle_props mlb_bus_cycle_props_inst (.clk_sys, .rstn, .cfg_bus8, .cpu_done,
   .dma_done, .sync_ready_in, .async_ready_in, .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe,
   .upper_addr_status_lines, .high_byte_lane_enable_n, .cycle_status_code, .ale, .rd_n, .wr_n,
   .data_buffer_enable_n, .data_buffer_direction);
`default_nettype wire

// file: tb/mlb_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mlb_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        bus8,
   input  wire logic [7:0]  wait_clks,
   input  wire logic        ale,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        bhe_n,
   input  wire logic [15:0] bus_out,
   input  wire logic        bus_oe,
   output var  logic [15:0] bus_in,
   output var  logic        ready
);
   logic [7:0]  mem [0:511];
   logic [9:0]  lat_a;
   logic [7:0]  cnt  = 8'h0;
   logic [15:0] last = 16'h0;
   wire  [8:0]  a    = lat_a[8:0];
   // ****************************************
   // latch, wait count, write lanes
   // ****************************************
   always @(posedge clk_sys) begin
      if (ale && bus_oe) lat_a <= {bhe_n, bus_out[8:0]};
      if (ale) cnt <= wait_clks;
      else if (cnt != 8'h0) cnt <= cnt - 8'h1;
      if (!wr_n) begin
         if (bus8) mem[a] <= bus_out[7:0];
         else begin
            if (!a[0]) mem[a] <= bus_out[7:0];
            if (!lat_a[9]) mem[a | 9'h1] <= bus_out[15:8];
         end
      end
      if (!rd_n) last <= bus_in;
   end
   assign ready = (cnt == 8'h0);
   // released bus shows the inverse of its last value, not a stale copy
   always @* begin
      if (!rd_n) bus_in = bus8 ? {~last[15:8], mem[a]} : {mem[a | 9'h1], mem[a & 9'h1fe]};
      else bus_in = ~last;
   end
endmodule // mlb_mem_model
`default_nettype wire

// file: tb/mlb_bus_cycle_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "mlb_regs.vh"
module mlb_bus_cycle_tb;
   logic        clk_sys = 1'b0, rstn = 1'b0, cfg_bus8 = 1'b0, cfg_pcs_addr = 1'b0, async_ready_in = 1'b0;
   logic        cpu_req = 1'b0, cpu_word = 1'b0, cpu_periph = 1'b0, dma_req = 1'b0, dma_word = 1'b0;
   logic        dma_periph = 1'b0;
   logic [2:0]  cpu_cyc = 3'h0, dma_cyc = 3'h0, st_seen;
   logic [19:0] cpu_addr = 20'h0, dma_addr = 20'h0;
   logic [15:0] cpu_wdata = 16'h0, dma_wdata = 16'h0;
   logic [7:0]  wait_clks = 8'h0;
   wire  [15:0] rd_data, muxed_addr_data_bus_in, muxed_addr_data_bus_out;
   wire  [3:0]  upper_addr_status_lines;
   wire  [2:0]  cycle_status_code;
   wire         cpu_done, dma_done, sync_ready_in, muxed_addr_data_bus_oe, high_byte_lane_enable_n, ale;
   wire         rd_n, wr_n, data_buffer_enable_n, data_buffer_direction, pcs_a1, pcs_a2, bus_clk_out;
   integer      miscompares = 0, checked = 0, ale_n = 0, n0, t_ale = 0, cyc_cnt = 0, lat, c;
   logic        ale_q = 1'b0;
   always #5 clk_sys = ~clk_sys;
   mlb_bus_cycle mlb_bus_cycle_inst (.clk_sys, .rstn, .cfg_bus8, .cfg_pcs_addr, .cpu_req, .cpu_cyc, .cpu_addr,
      .cpu_word, .cpu_periph, .cpu_wdata, .cpu_done, .dma_req, .dma_cyc, .dma_addr, .dma_word, .dma_periph,
      .dma_wdata, .dma_done, .rd_data, .sync_ready_in, .async_ready_in, .muxed_addr_data_bus_in,
      .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .upper_addr_status_lines, .high_byte_lane_enable_n,
      .cycle_status_code, .ale, .rd_n, .wr_n, .data_buffer_enable_n, .data_buffer_direction, .pcs_a1, .pcs_a2,
      .bus_clk_out);
   mlb_mem_model mlb_mem_model_inst (.clk_sys, .bus8(cfg_bus8), .wait_clks, .ale, .rd_n, .wr_n,
      .bhe_n(high_byte_lane_enable_n), .bus_out(muxed_addr_data_bus_out), .bus_oe(muxed_addr_data_bus_oe),
      .bus_in(muxed_addr_data_bus_in), .ready(sync_ready_in));
   always @(posedge clk_sys) begin
      ale_q <= ale;
      if (ale && !ale_q) begin
         ale_n = ale_n + 1;
         t_ale = cyc_cnt;
         st_seen = cycle_status_code;
      end
      cyc_cnt = cyc_cnt + 1;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic go(input logic dma, input logic [2:0] cyc, input logic [19:0] addr, input logic word,
                     input logic [15:0] wd);
      integer n;
      n = 0;
      n0 = ale_n;
      if (dma) {dma_cyc, dma_addr, dma_word, dma_wdata, dma_req} = {cyc, addr, word, wd, 1'b1};
      else {cpu_cyc, cpu_addr, cpu_word, cpu_wdata, cpu_req} = {cyc, addr, word, wd, 1'b1};
      while (!(cpu_done === 1'b1 || dma_done === 1'b1) && n < 400) begin
         @(posedge clk_sys);
         #1;
         n = n + 1;
      end
      check("done in time", n < 400, 1'b1);
      check("done owner", {dma_done, cpu_done}, dma ? 2'h2 : 2'h1);
      check("bus clock low at state start", bus_clk_out, 1'b0);
      lat = cyc_cnt - t_ale;
      cpu_req = 1'b0;
      dma_req = 1'b0;
      check("status code", st_seen, cyc);
      @(posedge clk_sys);
      #1;
      check("bus clock high at mid state", bus_clk_out, 1'b1);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_word;
      cfg_pcs_addr = 1'b1;
      go(0, `MLB_CYC_MEM_WR, 20'h30016, 1, 16'ha55a);
      check("even word one cycle", ale_n - n0, 1);
      check("even word mem", {mlb_mem_model_inst.mem[9'h17], mlb_mem_model_inst.mem[9'h16]}, 16'ha55a);
      go(0, `MLB_CYC_MEM_RD, 20'h30016, 1, 16'h0);
      check("word read", rd_data, 16'ha55a);
      check("cycle length", lat, 7);
      check("pcs bits", {pcs_a2, pcs_a1}, 2'h3);
      $display("word test over");
   endtask
   task automatic t_odd;
      go(1, `MLB_CYC_IO_WR, 20'h00021, 1, 16'h1234);
      check("odd word two cycles", ale_n - n0, 2);
      check("odd word mem", {mlb_mem_model_inst.mem[9'h22], mlb_mem_model_inst.mem[9'h21]}, 16'h1234);
      go(1, `MLB_CYC_MEM_RD, 20'h00021, 1, 16'h0);
      check("dma odd word read", rd_data, 16'h1234);
      check("dma cycle length", lat, 7);
      go(1, `MLB_CYC_MEM_RD, 20'h00022, 0, 16'h0);
      check("even byte read", rd_data[7:0], 8'h12);
      check("pcs bits even byte", {pcs_a2, pcs_a1}, 2'h1);
      go(0, `MLB_CYC_MEM_RD, 20'h00021, 0, 16'h0);
      check("odd byte read", rd_data[7:0], 8'h34);
      check("pcs bits odd byte", {pcs_a2, pcs_a1}, 2'h0);
      $display("odd test over");
   endtask
   task automatic t_wait;
      wait_clks = 8'h14;
      go(0, `MLB_CYC_MEM_RD, 20'h30016, 1, 16'h0);
      check("wait read", rd_data, 16'ha55a);
      check("waits extend cycle", lat > 22, 1'b1);
      check("whole wait states", (lat - 7) % 2, 0);
      // sync ready held off for long; only the async pin can end this cycle early
      wait_clks = 8'hff;
      fork
         go(0, `MLB_CYC_MEM_RD, 20'h30016, 1, 16'h0);
         begin
            repeat (30) @(posedge clk_sys);
            #1;
            async_ready_in = 1'b1;
         end
      join
      async_ready_in = 1'b0;
      check("async ready read", rd_data, 16'ha55a);
      check("async ready ends wait", lat < 60, 1'b1);
      wait_clks = 8'h0;
      $display("wait test over");
   endtask
   task automatic t_reset;
      {cpu_cyc, cpu_addr, cpu_word, cpu_req} = {`MLB_CYC_MEM_RD, 20'h30016, 1'b1, 1'b1};
      repeat (9) @(posedge clk_sys);
      #1;
      check("read under way", rd_n, 1'b0);
      rstn = 1'b0;
      cpu_req = 1'b0;
      #1;
      check("reset strobes", {ale, rd_n, wr_n, data_buffer_enable_n, muxed_addr_data_bus_oe}, 5'h0e);
      check("reset status", cycle_status_code, `MLB_CYC_PASSIVE);
      repeat (2) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      @(posedge clk_sys);
      #1;
      go(0, `MLB_CYC_MEM_RD, 20'h30016, 1, 16'h0);
      check("read after reset", rd_data, 16'ha55a);
      check("length after reset", lat, 7);
      $display("reset test over");
   endtask
   task automatic t_bus8;
      cfg_bus8 = 1'b1;
      go(0, `MLB_CYC_MEM_WR, 20'h00040, 1, 16'hbeef);
      check("8-bit word split", ale_n - n0, 2);
      check("8-bit word mem", {mlb_mem_model_inst.mem[9'h41], mlb_mem_model_inst.mem[9'h40]}, 16'hbeef);
      go(0, `MLB_CYC_MEM_RD, 20'h00040, 1, 16'h0);
      check("8-bit word read", rd_data, 16'hbeef);
      cpu_periph = 1'b1;
      cfg_pcs_addr = 1'b0;
      go(0, `MLB_CYC_IO_RD, 20'h00040, 1, 16'h0);
      check("periph one cycle", ale_n - n0, 1);
      check("pcs idle when off", {pcs_a2, pcs_a1}, 2'h3);
      cpu_periph = 1'b0;
      cfg_bus8 = 1'b0;
      $display("8-bit test over");
   endtask
   task automatic t_codes;
      for (c = 0; c < 7; c = c + 1) go(c[0], c[2:0], 20'h30016, 0, 16'h5ac3);
      $display("status test over");
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      @(posedge clk_sys);
      #1;
      t_word();
      t_odd();
      t_wait();
      t_reset();
      t_bus8();
      t_codes();
      stop_test();
   end
   initial begin
      #400000;
      miscompares = miscompares + 1;
      stop_test();
   end
endmodule // mlb_bus_cycle_tb
`default_nettype wire
